/* File: hdl/jpps_top.v */
// Test port pin sharing: TAP, shared pin muxing, probe outputs
//
// Overview of operation
// - Shared mode: TMS low claims TCK, TDI, TDO
// - Test pins held until test-logic-reset, then released
// - TMS high five TCK edges reaches reset
// - Dedicated mode: standard TAP, no sharing
// - Active-low scan reset, pulled up, asynchronous
// - TDO driven during checksum, released afterward
// - Two probe outputs show selected nodes live
// - Probe pins revert to I/O; fuse disables
// - HIGHZ tristates pads, configured pulls become active
// - TCK and TDI serve scan, probe, programming
`timescale 1ns/1ps
`include "jpps_consts.vh"

module jpps_top
(
   // Clock and reset
   input  wire                        clk,
   input  wire                        reset,
   input  wire                        ce,
   // Mode straps
   input  wire                        dedicated_mode,
   input  wire                        probe_enable,
   input  wire                        probe_fuse_blown,
   // Test pins
   input  wire                        tms_pin,
   input  wire                        trst_n_pin,
   input  wire                        trst_n_driven,
   input  wire                        tck_pin_in,
   output wire                        tck_pin_out,
   output wire                        tck_pin_oe,
   input  wire                        tdi_pin_in,
   output wire                        tdi_pin_out,
   output wire                        tdi_pin_oe,
   input  wire                        tdo_pin_in,
   output wire                        tdo_pin_out,
   output wire                        tdo_pin_oe,
   // User side of shared pins
   input  wire [2:0]                  user_out,
   input  wire [2:0]                  user_oe,
   output reg  [2:0]                  user_in,
   // Probe pins
   output wire                        probe_out_a_out,
   output wire                        probe_out_a_oe,
   output wire                        probe_out_b_out,
   output wire                        probe_out_b_oe,
   input  wire [1:0]                  user_probe_out,
   input  wire [1:0]                  user_probe_oe,
   input  wire [`JPPS_NODE_W-1:0]     probe_nodes,
   // Pad control
   input  wire [`JPPS_IO_W-1:0]       pull_up_cfg,
   input  wire [`JPPS_IO_W-1:0]       pull_dn_cfg,
   output wire                        io_highz,
   output wire [`JPPS_IO_W-1:0]       pad_pull_up_en,
   output wire [`JPPS_IO_W-1:0]       pad_pull_dn_en,
   // Checksum and programming
   input  wire [`JPPS_CSUM_W-1:0]     checksum,
   output reg                         prog_clk_pulse,
   output reg                         prog_data,
   // Status
   output wire                        tap_in_reset,
   output wire                        pins_in_test
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Bits: 0 tck, 1 tdi, 2 tdo, 3 tms, 4 trst_n, 5 trst driven
   wire [5:0] pin_raw;
   reg  [5:0] sync_a;
   reg  [5:0] sync_b;
   reg        tck_prev;
   // Reset to idle pin levels, or a false claim follows reset
   localparam [5:0] sync_idle = `JPPS_SYNC_IDLE;

   assign pin_raw = {trst_n_driven, trst_n_pin, tms_pin, tdo_pin_in, tdi_pin_in, tck_pin_in};

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1)
      begin : g_sync
         always @(posedge clk)
         begin
            if (reset)
            begin
               sync_a[gi] <= sync_idle[gi];
               sync_b[gi] <= sync_idle[gi];
            end
            else if (ce)
            begin
               sync_a[gi] <= pin_raw[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   wire tck_s   = sync_b[0];
   wire tdi_s   = sync_b[1];
   wire tms_s   = sync_b[3];
   // Undriven reset pin reads high through the pull-up
   wire trst_n  = ~sync_b[5] | sync_b[4];
   wire tck_r   = tck_s & ~tck_prev;
   wire tck_f   = ~tck_s & tck_prev;

   // ---------------------------------------------------------------
   // Pin ownership
   // ---------------------------------------------------------------
   reg  [3:0] tap_state;
   reg  [3:0] next_tap_state;
   reg        claim;
   reg        csum_busy;

   assign tap_in_reset = (tap_state == `JPPS_TLR);
   // One selector for TCK and TDI; TDO widens it below
   assign pins_in_test = dedicated_mode | claim;
   // TDO also taken while a checksum is being read back
   wire tdo_test = pins_in_test | csum_busy;
   // In shared mode the TAP ignores TCK until pins are claimed
   wire tap_clk_en = pins_in_test & tck_r;

   always @(posedge clk)
   begin
      if (reset)
      begin
         claim    <= 1'b0;
         tck_prev <= 1'b0;
      end
      else if (ce)
      begin
         tck_prev <= tck_s;
         if (!dedicated_mode && !tms_s)
            claim <= 1'b1;
         else if (tap_in_reset)
            claim <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // TAP state machine
   // ---------------------------------------------------------------
   always @*
   begin
      case (tap_state)
         `JPPS_TLR:  next_tap_state = tms_s ? `JPPS_TLR  : `JPPS_RTI;
         `JPPS_RTI:  next_tap_state = tms_s ? `JPPS_SDRS : `JPPS_RTI;
         `JPPS_SDRS: next_tap_state = tms_s ? `JPPS_SIRS : `JPPS_CDR;
         `JPPS_CDR:  next_tap_state = tms_s ? `JPPS_E1DR : `JPPS_SDR;
         `JPPS_SDR:  next_tap_state = tms_s ? `JPPS_E1DR : `JPPS_SDR;
         `JPPS_E1DR: next_tap_state = tms_s ? `JPPS_UDR  : `JPPS_PDR;
         `JPPS_PDR:  next_tap_state = tms_s ? `JPPS_E2DR : `JPPS_PDR;
         `JPPS_E2DR: next_tap_state = tms_s ? `JPPS_UDR  : `JPPS_SDR;
         `JPPS_UDR:  next_tap_state = tms_s ? `JPPS_SDRS : `JPPS_RTI;
         `JPPS_SIRS: next_tap_state = tms_s ? `JPPS_TLR  : `JPPS_CIR;
         `JPPS_CIR:  next_tap_state = tms_s ? `JPPS_E1IR : `JPPS_SIR;
         `JPPS_SIR:  next_tap_state = tms_s ? `JPPS_E1IR : `JPPS_SIR;
         `JPPS_E1IR: next_tap_state = tms_s ? `JPPS_UIR  : `JPPS_PIR;
         `JPPS_PIR:  next_tap_state = tms_s ? `JPPS_E2IR : `JPPS_PIR;
         `JPPS_E2IR: next_tap_state = tms_s ? `JPPS_UIR  : `JPPS_SIR;
         `JPPS_UIR:  next_tap_state = tms_s ? `JPPS_SDRS : `JPPS_RTI;
         default:    next_tap_state = `JPPS_TLR;
      endcase
   end

   // Scan reset acts at once, not waiting for a TCK edge
   always @(posedge clk)
   begin
      if (reset || !trst_n)
         tap_state <= `JPPS_TLR;
      else if (ce && tap_clk_en)
         tap_state <= next_tap_state;
   end

   // ---------------------------------------------------------------
   // Instruction and data registers
   // ---------------------------------------------------------------
   reg [`JPPS_IR_W-1:0]   ir_shift;
   reg [`JPPS_IR_W-1:0]   ir;
   reg [`JPPS_CSUM_W-1:0] dr_shift;
   reg [`JPPS_PSEL_W-1:0] probe_sel;
   reg [`JPPS_CNT_W-1:0]  csum_cnt;
   reg                    tdo_q;
   reg                    tdo_en;

   wire in_sdr = (tap_state == `JPPS_SDR);
   wire in_sir = (tap_state == `JPPS_SIR);
   wire is_csum  = (ir == `JPPS_INS_CSUM);
   wire is_probe = (ir == `JPPS_INS_PROBE);
   // Unknown codes fall back to the one-bit bypass path
   wire is_wide  = is_csum | is_probe;
   // Every data path, bypass too, leaves through bit 0
   wire dr_out   = dr_shift[0];

   always @(posedge clk)
   begin
      if (reset || !trst_n)
      begin
         ir_shift  <= {`JPPS_IR_W{1'b0}};
         ir        <= `JPPS_INS_BYP;
         dr_shift  <= {`JPPS_CSUM_W{1'b0}};
         probe_sel <= {`JPPS_PSEL_W{1'b0}};
         csum_cnt  <= {`JPPS_CNT_W{1'b0}};
         csum_busy <= 1'b0;
         tdo_q     <= 1'b0;
         tdo_en    <= 1'b0;
      end
      else if (ce)
      begin
         if (tap_clk_en)
         begin
            case (tap_state)
               `JPPS_TLR:
                  ir <= `JPPS_INS_BYP;
               `JPPS_CIR:
                  ir_shift <= `JPPS_IR_CAPT;
               `JPPS_SIR:
                  ir_shift <= {tdi_s, ir_shift[`JPPS_IR_W-1:1]};
               `JPPS_UIR:
               begin
                  ir <= ir_shift;
                  if (ir_shift == `JPPS_INS_CSUM)
                  begin
                     csum_busy <= 1'b1;
                     csum_cnt  <= {`JPPS_CNT_W{1'b0}};
                  end
               end
               `JPPS_CDR:
                  if (is_csum)
                     dr_shift <= checksum;
                  else if (is_probe)
                     dr_shift <= {{(`JPPS_CSUM_W-`JPPS_PSEL_W){1'b0}}, probe_sel};
                  else
                     dr_shift <= {`JPPS_CSUM_W{1'b0}};
               `JPPS_SDR:
               begin
                  if (is_probe)
                     dr_shift <= {{(`JPPS_CSUM_W-`JPPS_PSEL_W){1'b0}}, tdi_s,
                                  dr_shift[`JPPS_PSEL_W-1:1]};
                  else if (is_wide)
                     dr_shift <= {tdi_s, dr_shift[`JPPS_CSUM_W-1:1]};
                  else
                     dr_shift <= {tdi_s, dr_shift[`JPPS_CSUM_W-2:0]} >> (`JPPS_CSUM_W-1);
                  if (csum_busy && is_csum)
                  begin
                     csum_cnt <= csum_cnt + 1'b1;
                     // Done once every checksum bit has left
                     if (csum_cnt == `JPPS_CSUM_W-1)
                        csum_busy <= 1'b0;
                  end
               end
               `JPPS_UDR:
                  if (is_probe)
                     probe_sel <= dr_shift[`JPPS_PSEL_W-1:0];
               default:
                  ir <= ir;
            endcase
         end
         // Leaving the checksum instruction ends the readout
         if (csum_busy && !is_csum)
            csum_busy <= 1'b0;
         // TDO changes on the falling TCK edge
         if (tck_f)
         begin
            tdo_q  <= in_sir ? ir_shift[0] : dr_out;
            tdo_en <= in_sir | in_sdr;
         end
      end
   end

   // ---------------------------------------------------------------
   // Shared pin drivers
   // ---------------------------------------------------------------
   // TCK and TDI are inputs while owned by the test logic
   assign tck_pin_out = pins_in_test ? 1'b0 : user_out[0];
   assign tck_pin_oe  = pins_in_test ? 1'b0 : user_oe[0];
   assign tdi_pin_out = pins_in_test ? 1'b0 : user_out[1];
   assign tdi_pin_oe  = pins_in_test ? 1'b0 : user_oe[1];
   assign tdo_pin_out = tdo_test ? tdo_q : user_out[2];
   assign tdo_pin_oe  = tdo_test ? (tdo_en | csum_busy) : user_oe[2];

   always @(posedge clk)
   begin
      if (reset)
      begin
         user_in        <= 3'h0;
         prog_clk_pulse <= 1'b0;
         prog_data      <= 1'b0;
      end
      else if (ce)
      begin
         // User logic sees idle zero while a pin belongs to test
         user_in[0] <= pins_in_test ? 1'b0 : tck_s;
         user_in[1] <= pins_in_test ? 1'b0 : tdi_s;
         user_in[2] <= tdo_test ? 1'b0 : sync_b[2];
         // Programming is clocked by TCK with TDI as data
         prog_clk_pulse <= tap_clk_en && (ir == `JPPS_INS_PROG) && in_sdr;
         prog_data      <= tdi_s;
      end
   end

   // ---------------------------------------------------------------
   // Probe outputs
   // ---------------------------------------------------------------
   // Fuse input is never cleared here, so disable is permanent
   wire probing = probe_enable & ~probe_fuse_blown;
   // Node selection is combinational for real-time view
   wire node_a = probe_nodes[probe_sel[`JPPS_SEL_W-1:0]];
   wire node_b = probe_nodes[probe_sel[`JPPS_PSEL_W-1:`JPPS_SEL_W]];

   assign probe_out_a_out = probing ? node_a : user_probe_out[0];
   assign probe_out_a_oe  = probing ? 1'b1   : user_probe_oe[0];
   assign probe_out_b_out = probing ? node_b : user_probe_out[1];
   assign probe_out_b_oe  = probing ? 1'b1   : user_probe_oe[1];

   // ---------------------------------------------------------------
   // High-impedance instruction
   // ---------------------------------------------------------------
   assign io_highz       = (ir == `JPPS_INS_HIGHZ);
   assign pad_pull_up_en = io_highz ? pull_up_cfg : {`JPPS_IO_W{1'b0}};
   assign pad_pull_dn_en = io_highz ? pull_dn_cfg : {`JPPS_IO_W{1'b0}};

endmodule // jpps_top

/* File: hdl/jpps_consts.vh */
// Constants for the test port pin sharing block
`ifndef JPPS_CONSTS_VH
`define JPPS_CONSTS_VH
// TAP states
`define JPPS_TLR  4'h0
`define JPPS_RTI  4'h1
`define JPPS_SDRS 4'h2
`define JPPS_CDR  4'h3
`define JPPS_SDR  4'h4
`define JPPS_E1DR 4'h5
`define JPPS_PDR  4'h6
`define JPPS_E2DR 4'h7
`define JPPS_UDR  4'h8
`define JPPS_SIRS 4'h9
`define JPPS_CIR  4'hA
`define JPPS_SIR  4'hB
`define JPPS_E1IR 4'hC
`define JPPS_PIR  4'hD
`define JPPS_E2IR 4'hE
`define JPPS_UIR  4'hF
// Instructions
`define JPPS_IR_W      4
`define JPPS_INS_HIGHZ 4'h7
`define JPPS_INS_CSUM  4'h8
`define JPPS_INS_PROBE 4'h9
`define JPPS_INS_PROG  4'hA
`define JPPS_INS_BYP   4'hF
`define JPPS_IR_CAPT   4'h1
// Widths
`define JPPS_CSUM_W  16
`define JPPS_NODE_W  16
`define JPPS_SEL_W   4
`define JPPS_PSEL_W  8
`define JPPS_IO_W    8
`define JPPS_CNT_W   5
// Synchroniser reset levels: TMS and scan reset idle high
`define JPPS_SYNC_IDLE 6'h18
`endif

/* File: dv/jpps_monitor.sv */
// Port checker for the test port pin sharing block
`timescale 1ns/1ps
`include "jpps_consts.vh"
module jpps_monitor
(
   // Clock and reset
   input wire                    clk,
   input wire                    reset,
   input wire                    ce,
   // Straps and test pins
   input wire                    dedicated_mode,
   input wire                    probe_fuse_blown,
   input wire                    tms_pin,
   input wire                    tck_pin_out,
   input wire                    tck_pin_oe,
   input wire                    tdi_pin_oe,
   // User and probe side
   input wire [2:0]              user_out,
   input wire [2:0]              user_oe,
   input wire [2:0]              user_in,
   input wire                    probe_out_a_out,
   input wire                    probe_out_a_oe,
   input wire                    probe_out_b_out,
   input wire                    probe_out_b_oe,
   input wire [1:0]              user_probe_out,
   input wire [1:0]              user_probe_oe,
   // Pads and status
   input wire [`JPPS_IO_W-1:0]   pull_up_cfg,
   input wire [`JPPS_IO_W-1:0]   pull_dn_cfg,
   input wire                    io_highz,
   input wire [`JPPS_IO_W-1:0]   pad_pull_up_en,
   input wire [`JPPS_IO_W-1:0]   pad_pull_dn_en,
   input wire                    prog_clk_pulse,
   input wire                    tap_in_reset,
   input wire                    pins_in_test
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Two sync stages plus the flag register
   sequence s_tms_low_hold;
      (!tms_pin && ce) [*4];
   endsequence
   a_claim_on_tms: assert property (s_tms_low_hold |=> pins_in_test)
      else $error("pins not claimed after low select");
   a_claim_held: assert property (pins_in_test && !tap_in_reset && !dedicated_mode |=> pins_in_test)
      else $error("pins released outside test-logic-reset");
   a_release_tlr: assert property ($fell(pins_in_test) && !$past(reset) |-> $past(tap_in_reset))
      else $error("pins released without test-logic-reset");
   a_dedicated_test: assert property (dedicated_mode |-> pins_in_test && !tck_pin_oe)
      else $error("dedicated mode lost test pins");
   a_test_pins_float: assert property (pins_in_test |-> !tck_pin_oe && !tdi_pin_oe)
      else $error("test input pads driven");
   a_user_tck_pass: assert property (!pins_in_test |-> tck_pin_oe == user_oe[0] && tck_pin_out == user_out[0])
      else $error("user path not on clock pad");
   a_claimed_user_in: assert property (pins_in_test [*2] |-> user_in[1:0] == 2'h0)
      else $error("claimed pad seen by user");
   a_fuse_probe_off: assert property (probe_fuse_blown |-> probe_out_a_oe == user_probe_oe[0] &&
      probe_out_a_out == user_probe_out[0] && probe_out_b_oe == user_probe_oe[1] &&
      probe_out_b_out == user_probe_out[1])
      else $error("probe visible with fuse blown");
   a_highz_pulls: assert property (pad_pull_up_en == (io_highz ? pull_up_cfg : 8'h00) &&
      pad_pull_dn_en == (io_highz ? pull_dn_cfg : 8'h00))
      else $error("pad pulls wrong for high-z state");
   a_prog_pulse_one: assert property (prog_clk_pulse |=> !prog_clk_pulse)
      else $error("programming pulse too long");
endmodule // jpps_monitor

bind jpps_top jpps_monitor mon_u (.clk(clk), .reset(reset), .ce(ce), .dedicated_mode(dedicated_mode),
   .probe_fuse_blown(probe_fuse_blown), .tms_pin(tms_pin), .tck_pin_out(tck_pin_out), .tck_pin_oe(tck_pin_oe),
   .tdi_pin_oe(tdi_pin_oe), .user_out(user_out), .user_oe(user_oe), .user_in(user_in),
   .probe_out_a_out(probe_out_a_out), .probe_out_a_oe(probe_out_a_oe), .probe_out_b_out(probe_out_b_out),
   .probe_out_b_oe(probe_out_b_oe), .user_probe_out(user_probe_out), .user_probe_oe(user_probe_oe),
   .pull_up_cfg(pull_up_cfg), .pull_dn_cfg(pull_dn_cfg), .io_highz(io_highz), .pad_pull_up_en(pad_pull_up_en),
   .pad_pull_dn_en(pad_pull_dn_en), .prog_clk_pulse(prog_clk_pulse), .tap_in_reset(tap_in_reset),
   .pins_in_test(pins_in_test));

/* File: dv/jpps_tester.sv */
// External scan tester model driving the test pins
`timescale 1ns/1ps
module jpps_tester
(
   // Clock
   input  wire clk,
   // Tester pins
   output reg  tck,
   output reg  tms,
   output reg  tdi,
   input  wire tdo
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One 125 ns test clock period; TMS and TDI move on the fall
   task step(input reg m, input reg d, output reg q);
      begin
         tms <= m;
         tdi <= d;
         #62.5;
         q = tdo;
         tck <= 1'b1;
         #62.5;
         tck <= 1'b0;
      end
   endtask
   // From idle or reset: scan n bits LSB first, end in idle
   task shift(input reg ir, input reg [15:0] v, input integer n, output reg [15:0] cap);
      integer i;
      reg     q;
      begin
         cap = 16'h0000;
         // Frames start on a clock edge; the test clock stands still between them
         @(posedge clk);
         step(1'b0, 1'b0, q);
         step(1'b1, 1'b0, q);
         if (ir)
            step(1'b1, 1'b0, q);
         step(1'b0, 1'b0, q);
         step(1'b0, 1'b0, q);
         for (i = 0; i < n; i = i + 1)
         begin
            step(i == n - 1, v[i], q);
            cap[i] = q;
         end
         step(1'b1, 1'b0, q);
         step(1'b0, 1'b0, q);
      end
   endtask
   task reset5;
      integer i;
      reg     q;
      begin
         @(posedge clk);
         for (i = 0; i < 5; i = i + 1)
            step(1'b1, 1'b0, q);
      end
   endtask
endmodule // jpps_tester

/* File: dv/tb.sv */
// Self-checking bench for the test port pin sharing block
`timescale 1ns/1ps
`include "jpps_consts.vh"
module tb;
   reg clk, reset, ce, dedicated_mode, probe_enable, probe_fuse_blown, trst_n_pin, trst_n_driven;
   reg [2:0] user_out, user_oe;
   reg [1:0] user_probe_out, user_probe_oe;
   reg [15:0] probe_nodes, checksum, cap, v;
   reg [7:0] pull_up_cfg, pull_dn_cfg;
   wire tck, tms, tdi, tdo_pin_out, tdo_pin_oe, tck_pin_oe, tdi_pin_oe, pa_out, pa_oe, pb_out, pb_oe;
   wire io_highz, prog_clk_pulse, tap_in_reset, pins_in_test;
   wire [2:0] user_in;
   wire [7:0] pu_en, pd_en;
   // Released data line toggles so a stale bit cannot pass
   wire tdo_line = tdo_pin_oe ? tdo_pin_out : clk;
   integer seed, errors, n_tests, cycles, n_prog, k;
   jpps_top dut_u (.clk(clk), .reset(reset), .ce(ce), .dedicated_mode(dedicated_mode),
      .probe_enable(probe_enable), .probe_fuse_blown(probe_fuse_blown), .tms_pin(tms), .trst_n_pin(trst_n_pin),
      .trst_n_driven(trst_n_driven), .tck_pin_in(tck), .tck_pin_out(), .tck_pin_oe(tck_pin_oe),
      .tdi_pin_in(tdi), .tdi_pin_out(), .tdi_pin_oe(tdi_pin_oe), .tdo_pin_in(tdo_line),
      .tdo_pin_out(tdo_pin_out), .tdo_pin_oe(tdo_pin_oe), .user_out(user_out), .user_oe(user_oe),
      .user_in(user_in), .probe_out_a_out(pa_out), .probe_out_a_oe(pa_oe), .probe_out_b_out(pb_out),
      .probe_out_b_oe(pb_oe), .user_probe_out(user_probe_out), .user_probe_oe(user_probe_oe),
      .probe_nodes(probe_nodes), .pull_up_cfg(pull_up_cfg), .pull_dn_cfg(pull_dn_cfg), .io_highz(io_highz),
      .pad_pull_up_en(pu_en), .pad_pull_dn_en(pd_en), .checksum(checksum), .prog_clk_pulse(prog_clk_pulse),
      .prog_data(), .tap_in_reset(tap_in_reset), .pins_in_test(pins_in_test));
   jpps_tester tst_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp)
         begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task stop_test;
      begin
         if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // Pad-side traffic keeps changing under the checks
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      user_out <= $random(seed);
      user_oe <= $random(seed);
      user_probe_out <= $random(seed);
      user_probe_oe <= $random(seed);
      probe_nodes <= $random(seed);
      if (prog_clk_pulse === 1'b1)
         n_prog <= n_prog + 1;
      if (cycles == 40000)
      begin
         errors = errors + 1;
         stop_test;
      end
   end
   initial
   begin
      {reset, ce, trst_n_pin, trst_n_driven} = 4'hF;
      {dedicated_mode, probe_enable, probe_fuse_blown} = 3'h0;
      {user_out, user_oe, user_probe_out, user_probe_oe, probe_nodes} = 0;
      {checksum, cycles, n_prog, errors, n_tests} = 0;
      seed = 15;
      pull_up_cfg = 8'hA5;
      pull_dn_cfg = 8'h3C;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(negedge clk);
      check({pins_in_test, tap_in_reset}, 2'h1);
      tst_u.shift(1'b1, `JPPS_INS_HIGHZ, 4, cap);
      @(negedge clk);
      check(cap[3:0], `JPPS_IR_CAPT);
      check({pins_in_test, tck_pin_oe, tdi_pin_oe, user_in[1:0]}, 5'h10);
      check({io_highz, pu_en, pd_en}, {1'b1, pull_up_cfg, pull_dn_cfg});
      @(posedge clk);
      checksum <= $random(seed);
      tst_u.shift(1'b1, `JPPS_INS_CSUM, 4, cap);
      tst_u.shift(1'b0, 16'h0000, 16, cap);
      @(negedge clk);
      check(cap, checksum);
      // Readout over and pins still claimed: pad no longer driven as output
      check({tdo_pin_oe, io_highz}, 2'h0);
      tst_u.shift(1'b1, `JPPS_INS_PROG, 4, cap);
      tst_u.shift(1'b0, 16'h00FF, 8, cap);
      check(n_prog, 8);
      @(posedge clk);
      probe_enable <= 1'b1;
      for (k = 0; k < 3; k = k + 1)
      begin
         v = $random(seed);
         tst_u.shift(1'b1, `JPPS_INS_PROBE, 4, cap);
         tst_u.shift(1'b0, v, 8, cap);
         @(negedge clk);
         check({pa_oe, pb_oe, pa_out, pb_out}, {2'h3, probe_nodes[v[3:0]], probe_nodes[v[7:4]]});
      end
      @(posedge clk);
      probe_fuse_blown <= 1'b1;
      @(negedge clk);
      check({pa_oe, pa_out, pb_oe, pb_out}, {user_probe_oe[0], user_probe_out[0], user_probe_oe[1], user_probe_out[1]});
      tst_u.reset5;
      repeat (6) @(negedge clk);
      check({tap_in_reset, pins_in_test}, 2'h2);
      tst_u.shift(1'b1, `JPPS_INS_BYP, 4, cap);
      tst_u.shift(1'b0, v, 4, cap);
      check(cap[3:0], {v[2:0], 1'b0});
      // Undriven scan reset must read high through the pull-up
      @(posedge clk);
      {trst_n_pin, trst_n_driven} <= 2'h0;
      repeat (5) @(negedge clk);
      check(tap_in_reset, 1'b0);
      @(posedge clk);
      trst_n_driven <= 1'b1;
      repeat (5) @(negedge clk);
      check(tap_in_reset, 1'b1);
      @(posedge clk);
      trst_n_pin <= 1'b1;
      dedicated_mode <= 1'b1;
      tst_u.reset5;
      repeat (6) @(negedge clk);
      check({pins_in_test, tck_pin_oe, tdi_pin_oe}, 3'h4);
      stop_test;
   end
endmodule // tb
